// ==== src/iex_pkg.sv ====
/*
 Shared constants and types of the integer execute datapath.
 Assumes one core clock and a synchronous active-high reset.
*/
`default_nettype none
package iex_pkg;
   // Widths and indices
   localparam int XLEN = 64;
   localparam int NREG = 32;
   localparam int IDXW = 5;
   localparam int CNTW = 7;
   localparam int SHW = 6;
   localparam int W16_TOP = 15;
   localparam int W32_TOP = 31;
   localparam logic [4:0] ZERO_IDX = 5'h00;
   // Reset values and program counter step
   localparam logic [63:0] WORD_RST = 64'h0;
   localparam logic [63:0] PC_RST = 64'h0;
   localparam logic [63:0] PC_STEP = 64'h4;
   // Multiply and divide timing in pipeline clocks
   localparam logic [6:0] LAT_W16 = 7'h03;
   localparam logic [6:0] REP_W16 = 7'h02;
   localparam logic [1:0] STL_W16 = 2'h1;
   localparam logic [6:0] LAT_W32 = 7'h04;
   localparam logic [6:0] REP_W32 = 7'h03;
   localparam logic [1:0] STL_W32 = 2'h2;
   localparam logic [6:0] LAT_DW = 7'h06;
   localparam logic [6:0] REP_DW = 7'h05;
   localparam logic [6:0] LAT_DIVW = 7'h24;
   localparam logic [6:0] REP_DIVW = 7'h24;
   localparam logic [6:0] LAT_DIVD = 7'h44;
   localparam logic [6:0] REP_DIVD = 7'h44;
   // Operation codes
   typedef enum logic [4:0] {
      OP_NOP, OP_ADD, OP_SUB, OP_ADDR, OP_AND, OP_OR, OP_XOR, OP_NOR,
      OP_SLL, OP_SRL, OP_SRA, OP_SLT,
      OP_WPROD_S, OP_WPROD_U, OP_ACC_S, OP_ACC_U, OP_PROD_GPR,
      OP_DPROD_S, OP_DPROD_U, OP_WQUOT_S, OP_WQUOT_U, OP_DQUOT_S, OP_DQUOT_U,
      OP_MOVE_UPPER, OP_MOVE_BOTTOM
   } iex_op_t;
   // Timing classes of the multiply/divide unit
   typedef enum logic [2:0] {CLS_W16, CLS_W32, CLS_DW, CLS_DIVW, CLS_DIVD} iex_cls_t;
endpackage
`default_nettype wire

// ==== src/iex_md_if.sv ====
/*
 Carrier between the execute core and its multiply/divide unit.
 Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface iex_md_if;
   logic              start;
   iex_pkg::iex_op_t  op;
   logic [63:0]       a;
   logic [63:0]       b;
   iex_pkg::iex_cls_t cls;
   logic [6:0]        lat_left;
   logic              rep_busy;
   logic              gpr_pend;
   logic              prod_wr;
   logic [63:0]       prod;
   logic [63:0]       upper;
   logic [63:0]       bottom;
   modport unit (input start, op, a, b,
                 output cls, lat_left, rep_busy, gpr_pend, prod_wr, prod, upper, bottom);
   modport core (output start, op, a, b,
                 input cls, lat_left, rep_busy, gpr_pend, prod_wr, prod, upper, bottom);
endinterface
`default_nettype wire

// ==== src/iex_gpr.sv ====
/*
 General-purpose register file: two read ports, one write port.
 Assumes the write port is fed from the core's writeback stage.
*/
`timescale 1ns/1ps
`default_nettype none
module iex_gpr (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Read ports
   input  wire logic [4:0]  ra_idx,
   output logic      [63:0] ra_data,
   input  wire logic [4:0]  rb_idx,
   output logic      [63:0] rb_data,
   // Write port
   input  wire logic        we,
   input  wire logic [4:0]  w_idx,
   input  wire logic [63:0] w_data
);
   logic [63:0] mem_ff [iex_pkg::NREG];

   // Storage, entry zero stays at zero
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < iex_pkg::NREG; i++)
            mem_ff[i] <= iex_pkg::WORD_RST;
      end
      else if (we && w_idx != iex_pkg::ZERO_IDX)
         mem_ff[w_idx] <= w_data;
   end

   // Reads see a write of the same cycle
   assign ra_data = (ra_idx == iex_pkg::ZERO_IDX) ? iex_pkg::WORD_RST :
                    (we && w_idx == ra_idx) ? w_data : mem_ff[ra_idx];
   assign rb_data = (rb_idx == iex_pkg::ZERO_IDX) ? iex_pkg::WORD_RST :
                    (we && w_idx == rb_idx) ? w_data : mem_ff[rb_idx];

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_keep;
      we && w_idx != iex_pkg::ZERO_IDX ##1 !we && ra_idx == $past(w_idx) |-> ra_data == $past(w_data);
   endproperty
   a_keep: assert property (p_keep) else $error("stored word lost");
endmodule
`default_nettype wire

// ==== src/iex_mdu.sv ====
/*
 Pipelined multiply/divide unit with the upper/bottom result pair.
 Assumes the core starts an operation only when the repeat timer is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module iex_mdu (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Core side
   iex_md_if.unit    md
);
   logic [6:0]   lat_ff;
   logic [6:0]   rep_ff;
   logic [6:0]   nxt_lat;
   logic [6:0]   nxt_rep;
   logic [63:0]  pend_hi_ff;
   logic [63:0]  pend_lo_ff;
   logic [63:0]  upper_ff;
   logic [63:0]  bottom_ff;
   logic         to_gpr_ff;
   logic [63:0]  nxt_hi;
   logic [63:0]  nxt_lo;
   logic [63:0]  base_hi;
   logic [63:0]  base_lo;
   logic         sgn;
   logic         w16;
   logic [63:0]  wx;
   logic [63:0]  wy;
   logic [63:0]  wp;
   logic [63:0]  acc;
   logic [127:0] dp;
   logic [31:0]  wq;
   logic [31:0]  wr;
   logic [63:0]  dq;
   logic [63:0]  dr;

   function automatic logic fits16(input logic [63:0] v);
      return (&v[63:iex_pkg::W16_TOP]) | ~(|v[63:iex_pkg::W16_TOP]);
   endfunction

   function automatic logic [63:0] sx32(input logic [31:0] v);
      return {{32{v[31]}}, v};
   endfunction

   // Operand size and timing class
   assign w16 = fits16(md.a) & fits16(md.b);
   always_comb
   begin
      case (md.op)
         iex_pkg::OP_DPROD_S, iex_pkg::OP_DPROD_U: md.cls = iex_pkg::CLS_DW;
         iex_pkg::OP_WQUOT_S, iex_pkg::OP_WQUOT_U: md.cls = iex_pkg::CLS_DIVW;
         iex_pkg::OP_DQUOT_S, iex_pkg::OP_DQUOT_U: md.cls = iex_pkg::CLS_DIVD;
         default: md.cls = w16 ? iex_pkg::CLS_W16 : iex_pkg::CLS_W32;
      endcase
   end

   // Latency and repeat per class
   always_comb
   begin
      case (md.cls)
         iex_pkg::CLS_W16:  begin nxt_lat = iex_pkg::LAT_W16;  nxt_rep = iex_pkg::REP_W16;  end
         iex_pkg::CLS_DW:   begin nxt_lat = iex_pkg::LAT_DW;   nxt_rep = iex_pkg::REP_DW;   end
         iex_pkg::CLS_DIVW: begin nxt_lat = iex_pkg::LAT_DIVW; nxt_rep = iex_pkg::REP_DIVW; end
         iex_pkg::CLS_DIVD: begin nxt_lat = iex_pkg::LAT_DIVD; nxt_rep = iex_pkg::REP_DIVD; end
         default:           begin nxt_lat = iex_pkg::LAT_W32;  nxt_rep = iex_pkg::REP_W32;  end
      endcase
   end

   // Products of extended operands
   assign sgn = md.op inside {iex_pkg::OP_WPROD_S, iex_pkg::OP_ACC_S, iex_pkg::OP_PROD_GPR,
                              iex_pkg::OP_DPROD_S, iex_pkg::OP_WQUOT_S, iex_pkg::OP_DQUOT_S};
   assign wx = sgn ? sx32(md.a[31:0]) : {32'h0, md.a[31:0]};
   assign wy = sgn ? sx32(md.b[31:0]) : {32'h0, md.b[31:0]};
   assign wp = wx * wy;
   assign dp = {(sgn ? {64{md.a[63]}} : 64'h0), md.a} * {(sgn ? {64{md.b[63]}} : 64'h0), md.b};

   // Accumulate onto a result still in flight
   assign base_hi = (lat_ff != 7'h00 && !to_gpr_ff) ? pend_hi_ff : upper_ff;
   assign base_lo = (lat_ff != 7'h00 && !to_gpr_ff) ? pend_lo_ff : bottom_ff;
   assign acc = {base_hi[31:0], base_lo[31:0]} + wp;

   // Quotients, divide by zero gives all ones and the dividend
   always_comb
   begin
      wq = '1;
      wr = md.a[31:0];
      dq = '1;
      dr = md.a;
      // Signed and unsigned kept apart so neither turns the other unsigned
      if (md.b[31:0] != 32'h0)
      begin
         if (sgn)
         begin
            wq = $signed(md.a[31:0]) / $signed(md.b[31:0]);
            wr = $signed(md.a[31:0]) % $signed(md.b[31:0]);
         end
         else
         begin
            wq = md.a[31:0] / md.b[31:0];
            wr = md.a[31:0] % md.b[31:0];
         end
      end
      if (md.b != 64'h0)
      begin
         if (sgn)
         begin
            dq = $signed(md.a) / $signed(md.b);
            dr = $signed(md.a) % $signed(md.b);
         end
         else
         begin
            dq = md.a / md.b;
            dr = md.a % md.b;
         end
      end
   end

   // Result selection
   always_comb
   begin
      case (md.op)
         iex_pkg::OP_ACC_S, iex_pkg::OP_ACC_U:
            begin nxt_hi = sx32(acc[63:32]); nxt_lo = sx32(acc[31:0]); end
         iex_pkg::OP_DPROD_S, iex_pkg::OP_DPROD_U:
            begin nxt_hi = dp[127:64]; nxt_lo = dp[63:0]; end
         iex_pkg::OP_WQUOT_S, iex_pkg::OP_WQUOT_U:
            begin nxt_hi = sx32(wr); nxt_lo = sx32(wq); end
         iex_pkg::OP_DQUOT_S, iex_pkg::OP_DQUOT_U:
            begin nxt_hi = dr; nxt_lo = dq; end
         default:
            begin nxt_hi = sx32(wp[63:32]); nxt_lo = sx32(wp[31:0]); end
      endcase
   end

   // Latency and repeat timers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         lat_ff <= 7'h00;
         rep_ff <= 7'h00;
      end
      else if (md.start)
      begin
         lat_ff <= nxt_lat - 7'h01;
         rep_ff <= nxt_rep - 7'h01;
      end
      else
      begin
         if (lat_ff != 7'h00) lat_ff <= lat_ff - 7'h01;
         if (rep_ff != 7'h00) rep_ff <= rep_ff - 7'h01;
      end
   end

   // Result in flight
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pend_hi_ff <= iex_pkg::WORD_RST;
         pend_lo_ff <= iex_pkg::WORD_RST;
         to_gpr_ff  <= 1'b0;
      end
      else if (md.start)
      begin
         pend_hi_ff <= nxt_hi;
         pend_lo_ff <= nxt_lo;
         to_gpr_ff  <= (md.op == iex_pkg::OP_PROD_GPR);
      end
   end

   // Upper/bottom pair, untouched by product-to-register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         upper_ff  <= iex_pkg::WORD_RST;
         bottom_ff <= iex_pkg::WORD_RST;
      end
      else if (lat_ff == 7'h01 && !to_gpr_ff)
      begin
         upper_ff  <= pend_hi_ff;
         bottom_ff <= pend_lo_ff;
      end
   end

   // Outputs to the core
   assign md.lat_left = lat_ff;
   assign md.rep_busy = (rep_ff != 7'h00);
   assign md.gpr_pend = to_gpr_ff && (lat_ff != 7'h00);
   assign md.prod_wr  = to_gpr_ff && (lat_ff == 7'h01);
   assign md.prod     = pend_lo_ff;
   assign md.upper    = upper_ff;
   assign md.bottom   = bottom_ff;
endmodule
`default_nettype wire

// ==== src/iex_core.sv ====
/*
 Integer execute datapath: register file, single-cycle adder and
 logic unit, multiply/divide unit, interlocks and program counter.
 Assumes the issue logic holds an operation while issue_stall is high.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Thirty-two 64-bit general registers
// - Two read ports, one write port
// - Pending results forwarded to readers
// - Adder does address, add, subtract
// - Logic unit does logic and shifts
// - Adder and logic finish in one cycle
// - Small word product: latency 3, repeat 2
// - Small product-to-register: 3, 2, one stall
// - Doubleword products: latency 6, repeat 5
// - Word quotients take 36 clocks
// - Doubleword quotients take 68 clocks
// - Products and quotients, except product-to-register, go to result pair
// - Move-from copies pair into register
// - Product-to-register skips the result pair
// - Accumulate adds product to pair
// - Unit pipelined, gated by repeat interval
// - Operand size picks the timing
// - Interlocks stall on busy or unready
// - Registers, pair and PC are 64-bit
module iex_core (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Issue
   input  wire logic              op_valid,
   input  wire iex_pkg::iex_op_t  op_code,
   input  wire logic [4:0]        rs_idx,
   input  wire logic [4:0]        rt_idx,
   input  wire logic [4:0]        rd_idx,
   input  wire logic              use_imm,
   input  wire logic [63:0]       imm,
   output logic                   issue_stall,
   // Program counter
   input  wire logic              pc_load,
   input  wire logic [63:0]       pc_target,
   output logic      [63:0]       pc,
   // Address generation
   output logic                   agen_valid,
   output logic      [63:0]       agen_addr,
   // Writeback
   output logic                   wb_valid,
   output logic      [4:0]        wb_idx,
   output logic      [63:0]       wb_data
);
   iex_md_if    md ();
   logic [63:0] rs_val;
   logic [63:0] rt_val;
   logic [63:0] opb;
   logic [63:0] alu_res;
   logic [63:0] sum_chk;
   logic        accept;
   logic        is_md;
   logic        is_mf;
   logic        wr_gpr;
   logic        dep;
   logic [1:0]  stl_ff;
   logic [4:0]  pend_rd_ff;
   logic        wb_valid_ff;
   logic [4:0]  wb_idx_ff;
   logic [63:0] wb_data_ff;
   logic        agen_valid_ff;
   logic [63:0] agen_addr_ff;
   logic [63:0] pc_ff;

   // Register file, written from writeback
   iex_gpr u_gpr (
      .clk     (clk),
      .rst     (rst),
      .ra_idx  (rs_idx),
      .ra_data (rs_val),
      .rb_idx  (rt_idx),
      .rb_data (rt_val),
      .we      (wb_valid_ff),
      .w_idx   (wb_idx_ff),
      .w_data  (wb_data_ff)
   );

   // Multiply/divide unit
   iex_mdu u_mdu (
      .clk (clk),
      .rst (rst),
      .md  (md)
   );

   // Decode classes
   assign is_md = op_code inside {[iex_pkg::OP_WPROD_S:iex_pkg::OP_DQUOT_U]};
   assign is_mf = op_code inside {iex_pkg::OP_MOVE_UPPER, iex_pkg::OP_MOVE_BOTTOM};
   assign wr_gpr = op_code inside {[iex_pkg::OP_ADD:iex_pkg::OP_SUB], [iex_pkg::OP_AND:iex_pkg::OP_SLT],
                                   iex_pkg::OP_MOVE_UPPER, iex_pkg::OP_MOVE_BOTTOM};

   // Hazard on a register still awaiting its product
   assign dep = md.gpr_pend && (rs_idx == pend_rd_ff || rt_idx == pend_rd_ff || rd_idx == pend_rd_ff);

   // Interlock
   assign issue_stall = op_valid && (stl_ff != 2'h0
                                     || (is_md && md.rep_busy)
                                     || (is_mf && md.lat_left != 7'h00)
                                     || dep
                                     || (wr_gpr && md.prod_wr));
   assign accept = op_valid && !issue_stall;

   // Unit launch
   assign md.start = accept && is_md;
   assign md.op    = op_code;
   assign md.a     = rs_val;
   assign md.b     = rt_val;

   // Adder and logic unit, one cycle
   assign opb = use_imm ? imm : rt_val;
   assign sum_chk = rs_val + opb;
   always_comb
   begin
      case (op_code)
         iex_pkg::OP_ADD, iex_pkg::OP_ADDR: alu_res = rs_val + opb;
         iex_pkg::OP_SUB:         alu_res = rs_val - opb;
         iex_pkg::OP_AND:         alu_res = rs_val & opb;
         iex_pkg::OP_OR:          alu_res = rs_val | opb;
         iex_pkg::OP_XOR:         alu_res = rs_val ^ opb;
         iex_pkg::OP_NOR:         alu_res = ~(rs_val | opb);
         iex_pkg::OP_SLL:         alu_res = rs_val << opb[iex_pkg::SHW-1:0];
         iex_pkg::OP_SRL:         alu_res = rs_val >> opb[iex_pkg::SHW-1:0];
         iex_pkg::OP_SRA:         alu_res = $signed(rs_val) >>> opb[iex_pkg::SHW-1:0];
         iex_pkg::OP_SLT:         alu_res = {63'h0, $signed(rs_val) < $signed(opb)};
         iex_pkg::OP_MOVE_UPPER:  alu_res = md.upper;
         iex_pkg::OP_MOVE_BOTTOM: alu_res = md.bottom;
         default:                 alu_res = iex_pkg::WORD_RST;
      endcase
   end

   // Stall timer of product-to-register
   always_ff @(posedge clk)
   begin
      if (rst)
         stl_ff <= 2'h0;
      else if (accept && op_code == iex_pkg::OP_PROD_GPR)
         stl_ff <= (md.cls == iex_pkg::CLS_W16) ? iex_pkg::STL_W16 : iex_pkg::STL_W32;
      else if (stl_ff != 2'h0)
         stl_ff <= stl_ff - 2'h1;
   end

   // Destination of the product in flight
   always_ff @(posedge clk)
   begin
      if (rst)
         pend_rd_ff <= iex_pkg::ZERO_IDX;
      else if (accept && op_code == iex_pkg::OP_PROD_GPR)
         pend_rd_ff <= rd_idx;
   end

   // Writeback stage, product has priority
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wb_valid_ff <= 1'b0;
         wb_idx_ff   <= iex_pkg::ZERO_IDX;
         wb_data_ff  <= iex_pkg::WORD_RST;
      end
      else if (md.prod_wr)
      begin
         wb_valid_ff <= 1'b1;
         wb_idx_ff   <= pend_rd_ff;
         wb_data_ff  <= md.prod;
      end
      else if (accept && wr_gpr)
      begin
         wb_valid_ff <= 1'b1;
         wb_idx_ff   <= rd_idx;
         wb_data_ff  <= alu_res;
      end
      else
         wb_valid_ff <= 1'b0;
   end

   // Load/store address
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         agen_valid_ff <= 1'b0;
         agen_addr_ff  <= iex_pkg::WORD_RST;
      end
      else
      begin
         agen_valid_ff <= accept && op_code == iex_pkg::OP_ADDR;
         if (accept && op_code == iex_pkg::OP_ADDR)
            agen_addr_ff <= alu_res;
      end
   end

   // Program counter
   always_ff @(posedge clk)
   begin
      if (rst)
         pc_ff <= iex_pkg::PC_RST;
      else if (pc_load)
         pc_ff <= pc_target;
      else if (accept)
         pc_ff <= pc_ff + iex_pkg::PC_STEP;
   end

   // Outputs
   assign pc         = pc_ff;
   assign agen_valid = agen_valid_ff;
   assign agen_addr  = agen_addr_ff;
   assign wb_valid   = wb_valid_ff;
   assign wb_idx     = wb_idx_ff;
   assign wb_data    = wb_data_ff;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_add;
      accept && op_code == iex_pkg::OP_ADD |=> wb_valid_ff && wb_data_ff == $past(sum_chk);
   endproperty
   a_add: assert property (p_add) else $error("add result wrong");

   property p_xor;
      accept && op_code == iex_pkg::OP_XOR |=> wb_data_ff == ($past(rs_val) ^ $past(opb));
   endproperty
   a_xor: assert property (p_xor) else $error("logic result wrong");

   property p_w16;
      md.start && md.cls == iex_pkg::CLS_W16 |=> md.rep_busy && md.lat_left == 7'h02
         ##1 !md.rep_busy && md.lat_left == 7'h01;
   endproperty
   a_w16: assert property (p_w16) else $error("small word timing wrong");

   property p_w32;
      md.start && md.cls == iex_pkg::CLS_W32 |=> md.rep_busy [*2] ##1 !md.rep_busy && md.lat_left == 7'h01;
   endproperty
   a_w32: assert property (p_w32) else $error("large word timing wrong");

   property p_pg16;
      accept && op_code == iex_pkg::OP_PROD_GPR && md.cls == iex_pkg::CLS_W16
         |=> stl_ff != 2'h0 ##1 stl_ff == 2'h0 ##1 wb_valid_ff && wb_idx_ff == $past(rd_idx, 3);
   endproperty
   a_pg16: assert property (p_pg16) else $error("small product-to-register wrong");

   property p_pg32;
      accept && op_code == iex_pkg::OP_PROD_GPR && md.cls == iex_pkg::CLS_W32
         |=> (stl_ff != 2'h0) [*2] ##1 stl_ff == 2'h0 ##1 wb_valid_ff && wb_idx_ff == $past(rd_idx, 4);
   endproperty
   a_pg32: assert property (p_pg32) else $error("large product-to-register wrong");

   property p_dw;
      md.start && md.cls == iex_pkg::CLS_DW |=> md.rep_busy [*4] ##1 !md.rep_busy && md.lat_left == 7'h01;
   endproperty
   a_dw: assert property (p_dw) else $error("doubleword product timing wrong");

   property p_qw;
      md.start && md.cls == iex_pkg::CLS_DIVW |-> ##35 md.lat_left == 7'h01 ##1 !md.rep_busy;
   endproperty
   a_qw: assert property (p_qw) else $error("word quotient timing wrong");

   property p_qd;
      md.start && md.cls == iex_pkg::CLS_DIVD |-> ##67 md.lat_left == 7'h01 ##1 !md.rep_busy;
   endproperty
   a_qd: assert property (p_qd) else $error("doubleword quotient timing wrong");

   property p_mf;
      op_valid && is_mf && md.lat_left != 7'h00 |-> issue_stall;
   endproperty
   a_mf: assert property (p_mf) else $error("early move-from not held");

   property p_mfb;
      accept && op_code == iex_pkg::OP_MOVE_BOTTOM |=> wb_data_ff == $past(md.bottom);
   endproperty
   a_mfb: assert property (p_mfb) else $error("move-from value wrong");

   c_pg16: cover property (accept && op_code == iex_pkg::OP_PROD_GPR && md.cls == iex_pkg::CLS_W16);
   c_chain: cover property (md.start && md.op == iex_pkg::OP_ACC_S ##2 md.start && md.op == iex_pkg::OP_ACC_S);
   c_qd: cover property (md.start && md.cls == iex_pkg::CLS_DIVD);
endmodule
`default_nettype wire

// ==== dv/iex_issue_model.sv ====
/*
 Issue-side model: offers one operation and holds it until taken.
 Assumes the core samples on the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module iex_issue_model (
   // Clock and handshake
   input  wire logic        clk,
   input  wire logic        issue_stall,
   // Operation
   output logic             op_valid,
   output iex_pkg::iex_op_t op_code,
   output logic      [4:0]  rs_idx,
   output logic      [4:0]  rt_idx,
   output logic      [4:0]  rd_idx,
   output logic             use_imm,
   output logic      [63:0] imm
);
   int cyc = 0;
   // Edge count used to time answers
   always @(posedge clk) cyc <= cyc + 1;
   // Idle bus at time zero
   initial
   begin
      op_valid = 1'b0;
      op_code = iex_pkg::OP_NOP;
      rs_idx = 5'h00;
      rt_idx = 5'h00;
      rd_idx = 5'h00;
      use_imm = 1'b0;
      imm = 64'h0;
   end
   // Hold the request until an edge sees no stall
   task automatic issue(input iex_pkg::iex_op_t op, input logic [4:0] s, input logic [4:0] r,
                        input logic [4:0] d, input logic [63:0] v, output int t);
      logic st;
      st = 1'b1;
      // A fresh request waits one edge after the last release
      if (op_valid !== 1'b1)
      begin
         @(posedge clk);
         #1;
      end
      op_valid = 1'b1;
      op_code = op;
      rs_idx = s;
      rt_idx = r;
      rd_idx = d;
      use_imm = (v !== 64'h0);
      imm = v;
      repeat (80)
      begin
         @(negedge clk);
         st = issue_stall;
         @(posedge clk);
         #1;
         if (st === 1'b0) break;
      end
      // Count of the cycle in which the request was taken
      t = (st === 1'b0) ? cyc - 1 : -1000;
   endtask
   // Release the request after the taking edge
   task automatic rest;
      op_valid = 1'b0;
      imm = ~imm;
   endtask
endmodule
`default_nettype wire

// ==== dv/tb_iex_core.sv ====
/*
 Self-checking bench of the integer execute datapath.
 Assumes the issue model drives operations 1 ns after the clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_iex_core;
   logic             clk;
   logic             rst;
   logic             op_valid;
   iex_pkg::iex_op_t op_code;
   logic [4:0]       rs_idx;
   logic [4:0]       rt_idx;
   logic [4:0]       rd_idx;
   logic             use_imm;
   logic [63:0]      imm;
   logic             issue_stall;
   logic             pc_load;
   logic [63:0]      pc_target;
   logic [63:0]      pc;
   logic             agen_valid;
   logic [63:0]      agen_addr;
   logic             wb_valid;
   logic [4:0]       wb_idx;
   logic [63:0]      wb_data;
   int               n_fail = 0;
   int               num_checks = 0;
   int               t;
   // Device and issue model
   iex_core uut (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .rs_idx(rs_idx),
                 .rt_idx(rt_idx), .rd_idx(rd_idx), .use_imm(use_imm), .imm(imm),
                 .issue_stall(issue_stall), .pc_load(pc_load), .pc_target(pc_target), .pc(pc),
                 .agen_valid(agen_valid), .agen_addr(agen_addr), .wb_valid(wb_valid),
                 .wb_idx(wb_idx), .wb_data(wb_data));
   iex_issue_model u_iss (.clk(clk), .issue_stall(issue_stall), .op_valid(op_valid),
                          .op_code(op_code), .rs_idx(rs_idx), .rt_idx(rt_idx),
                          .rd_idx(rd_idx), .use_imm(use_imm), .imm(imm));
   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Value compare
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Wait for a writeback and judge delay, index and data
   task automatic wait_wb(input int t0, input logic [4:0] d, input logic [63:0] exp, input int dly);
      int k;
      k = 0;
      // The pulse may already stand when called
      while (wb_valid !== 1'b1 && k < 100)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      chk(64'(u_iss.cyc - t0), 64'(dly));
      chk({59'h0, wb_idx}, {59'h0, d});
      chk(wb_data, exp);
   endtask
   // Single-cycle adder or logic operation
   task automatic alu(input iex_pkg::iex_op_t op, input logic [4:0] s, input logic [4:0] r,
                      input logic [4:0] d, input logic [63:0] v, input logic [63:0] exp);
      u_iss.issue(op, s, r, d, v, t);
      u_iss.rest();
      wait_wb(t, d, exp, 1);
   endtask
   // Result-pair operation, then an early move-from that must wait
   task automatic md(input iex_pkg::iex_op_t op, input iex_pkg::iex_op_t mv, input logic [4:0] s,
                     input logic [4:0] r, input logic [4:0] d, input int lat, input logic [63:0] exp);
      int t0;
      u_iss.issue(op, s, r, 5'h00, 64'h0, t0);
      u_iss.issue(mv, 5'h00, 5'h00, d, 64'h0, t);
      u_iss.rest();
      chk(64'(t - t0), 64'(lat));
      wait_wb(t, d, exp, 1);
   endtask
   // Address generation pulse and value
   task automatic agen_test;
      u_iss.issue(iex_pkg::OP_ADDR, 5'h03, 5'h00, 5'h00, 64'h10, t);
      u_iss.rest();
      chk({63'h0, agen_valid}, 64'h1);
      chk(agen_addr, 64'h10010);
   endtask
   // Large operand product straight into a register
   task automatic prod_gpr_test;
      int t2;
      u_iss.issue(iex_pkg::OP_PROD_GPR, 5'h03, 5'h01, 5'h08, 64'h0, t);
      u_iss.rest();
      wait_wb(t, 5'h08, 64'h30000, 4);
      // Small product, then a reader of its register held until the write
      u_iss.issue(iex_pkg::OP_PROD_GPR, 5'h01, 5'h02, 5'h0c, 64'h0, t);
      u_iss.issue(iex_pkg::OP_ADD, 5'h0c, 5'h00, 5'h0b, 64'h1, t2);
      u_iss.rest();
      chk(64'(t2 - t), 64'h3);
      wait_wb(t2, 5'h0b, 64'h10, 1);
   endtask
   // Program counter load
   task automatic pc_test;
      @(posedge clk);
      #1;
      pc_load = 1'b1;
      pc_target = 64'h1000;
      @(posedge clk);
      #1;
      pc_load = 1'b0;
      chk(pc, 64'h1000);
   endtask
   // Verdict
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      rst = 1'b1;
      pc_load = 1'b0;
      pc_target = 64'h0;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      chk(pc, 64'h0);
      alu(iex_pkg::OP_ADD, 5'h00, 5'h00, 5'h01, 64'h3, 64'h3);
      alu(iex_pkg::OP_ADD, 5'h00, 5'h00, 5'h02, 64'h5, 64'h5);
      alu(iex_pkg::OP_ADD, 5'h00, 5'h00, 5'h03, 64'h10000, 64'h10000);
      alu(iex_pkg::OP_SUB, 5'h02, 5'h01, 5'h04, 64'h0, 64'h2);
      alu(iex_pkg::OP_XOR, 5'h03, 5'h00, 5'h05, 64'hff, 64'h100ff);
      alu(iex_pkg::OP_SLL, 5'h01, 5'h00, 5'h06, 64'h4, 64'h30);
      alu(iex_pkg::OP_SUB, 5'h00, 5'h00, 5'h0d, 64'h5, 64'hfffffffffffffffb);
      agen_test();
      md(iex_pkg::OP_WPROD_S, iex_pkg::OP_MOVE_BOTTOM, 5'h01, 5'h02, 5'h07, 3, 64'hf);
      md(iex_pkg::OP_ACC_S, iex_pkg::OP_MOVE_BOTTOM, 5'h01, 5'h02, 5'h0a, 3, 64'h1e);
      prod_gpr_test();
      md(iex_pkg::OP_WQUOT_U, iex_pkg::OP_MOVE_UPPER, 5'h01, 5'h02, 5'h09, 36, 64'h3);
      md(iex_pkg::OP_WQUOT_S, iex_pkg::OP_MOVE_BOTTOM, 5'h0d, 5'h04, 5'h0e, 36, 64'hfffffffffffffffe);
      md(iex_pkg::OP_DPROD_S, iex_pkg::OP_MOVE_UPPER, 5'h0d, 5'h01, 5'h0f, 6, 64'hffffffffffffffff);
      md(iex_pkg::OP_DQUOT_U, iex_pkg::OP_MOVE_BOTTOM, 5'h0d, 5'h02, 5'h10, 68, 64'h3333333333333332);
      chk(pc, 64'h5c);
      pc_test();
      summarize();
   end
endmodule
`default_nettype wire
